// [link_init_ctrl.v]
// Link initialization controller for a single-lane or dual-width serial port
`timescale 1ns/1ps
`default_nettype none
`include "lane_align_defines.vh"

module link_init_ctrl #(
    parameter QUAD_CAPABLE = 1,
    parameter [`TIMER_W-1:0] QUIET_COUNT = `QUIET_CYCLES,
    parameter [`TIMER_W-1:0] PROBE_COUNT = `PROBE_CYCLES
) (
    input wire core_clk,
    input wire resetn,
    input wire reinit_request,
    input wire single_lane_override,
    input wire alt_lane_override,
    input wire [3:0] lane_locked,
    input wire column_valid,
    input wire [3:0] lane_marker,
    input wire tx_control_valid,
    input wire tx_packet_valid,
    output reg link_up,
    output reg quad_mode,
    output reg alt_lane_select,
    output reg lane02_drive_en,
    output reg lane13_drive_en,
    output reg [1:0] tx_select,
    output reg tx_control_taken,
    output reg tx_packet_taken,
    output reg all_lanes_locked,
    output reg column_mismatch,
    output reg full_marker_column
);

    ////////////////////////////////////////////////////////////////////////////////
    // Alignment monitor, present only on quad-capable ports

    wire mon_locked;
    wire mon_mismatch;
    wire mon_full;
    wire every_lane_locked;

    assign every_lane_locked = &lane_locked;

    generate
        if (QUAD_CAPABLE != 0) begin : g_align
            lane_align_monitor u_align (
                .core_clk(core_clk),
                .resetn(resetn),
                .column_valid(column_valid),
                .lane_marker(lane_marker),
                .every_lane_locked(every_lane_locked),
                .all_lanes_locked(mon_locked),
                .column_mismatch(mon_mismatch),
                .full_marker_column(mon_full)
            );
        end else begin : g_no_align
            assign mon_locked = 1'b0;
            assign mon_mismatch = 1'b0;
            assign mon_full = 1'b0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Quiet and probe timers

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [`TIMER_W-1:0] quiet_cnt_q;
    reg [`TIMER_W-1:0] probe_cnt_q;
    wire quiet_en;
    wire probe_en;
    wire quiet_interval_elapsed;
    wire probe_window_elapsed;

    assign quiet_en = (state_q == `IN_QUIET);
    assign probe_en = (state_q == `IN_PROBE);
    assign quiet_interval_elapsed = (quiet_cnt_q >= QUIET_COUNT);
    assign probe_window_elapsed = (probe_cnt_q >= PROBE_COUNT);

    function [`TIMER_W-1:0] timer_next;
        input en;
        input [`TIMER_W-1:0] cnt;
        input [`TIMER_W-1:0] limit;
        begin
            if (!en) begin
                timer_next = {`TIMER_W{1'b0}};
            end else if (cnt >= limit) begin
                timer_next = cnt;
            end else begin
                timer_next = cnt + {{(`TIMER_W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    always @(posedge core_clk) begin
        if (!resetn || reinit_request) begin
            quiet_cnt_q <= {`TIMER_W{1'b0}};
            probe_cnt_q <= {`TIMER_W{1'b0}};
        end else begin
            quiet_cnt_q <= timer_next(quiet_en, quiet_cnt_q, QUIET_COUNT);
            probe_cnt_q <= timer_next(probe_en, probe_cnt_q, PROBE_COUNT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Initialization state machine

    function is_link_state;
        input [2:0] st;
        begin
            is_link_state = (st == `IN_SINGLE) || (st == `IN_PRIMARY)
                || (st == `IN_ALTERNATE) || (st == `IN_QUAD);
        end
    endfunction

    always @* begin
        state_d = state_q;
        case (state_q)
            `IN_QUIET: begin
                if (quiet_interval_elapsed) begin
                    state_d = `IN_SEARCH;
                end
            end
            `IN_SEARCH: begin
                if (QUAD_CAPABLE == 0) begin
                    if (lane_locked[0]) begin
                        state_d = `IN_SINGLE;
                    end
                end else if (lane_locked[0] || lane_locked[2]) begin
                    state_d = `IN_PROBE;
                end
            end
            `IN_PROBE: begin
                if (mon_locked && !single_lane_override) begin
                    state_d = `IN_QUAD;
                end else if (probe_window_elapsed) begin
                    if (lane_locked[0] && !alt_lane_override) begin
                        state_d = `IN_PRIMARY;
                    end else if (alt_lane_override || lane_locked[2]) begin
                        state_d = `IN_ALTERNATE;
                    end else begin
                        state_d = `IN_QUIET;
                    end
                end
            end
            `IN_SINGLE: begin
                if (!lane_locked[0]) begin
                    state_d = `IN_QUIET;
                end
            end
            `IN_PRIMARY: begin
                if (!lane_locked[0]) begin
                    state_d = `IN_QUIET;
                end
            end
            `IN_ALTERNATE: begin
                if (!lane_locked[2]) begin
                    state_d = `IN_QUIET;
                end
            end
            `IN_QUAD: begin
                if (!mon_locked || !every_lane_locked) begin
                    state_d = `IN_QUIET;
                end
            end
            default: state_d = `IN_QUIET;
        endcase
        if (reinit_request) begin
            state_d = `IN_QUIET;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs and transmit arbitration

    reg link_d;
    reg [1:0] tx_sel_d;

    always @* begin
        link_d = is_link_state(state_d);
        tx_sel_d = `TX_IDLE;
        if (link_d) begin
            if (tx_control_valid) begin
                tx_sel_d = `TX_CONTROL;
            end else if (tx_packet_valid) begin
                tx_sel_d = `TX_PACKET;
            end
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= `IN_QUIET;
            link_up <= 1'b0;
            quad_mode <= 1'b0;
            alt_lane_select <= 1'b0;
            lane02_drive_en <= 1'b0;
            lane13_drive_en <= 1'b0;
            tx_select <= `TX_IDLE;
            tx_control_taken <= 1'b0;
            tx_packet_taken <= 1'b0;
            all_lanes_locked <= 1'b0;
            column_mismatch <= 1'b0;
            full_marker_column <= 1'b0;
        end else begin
            state_q <= state_d;
            link_up <= link_d;
            quad_mode <= (state_d == `IN_QUAD);
            alt_lane_select <= (state_d == `IN_ALTERNATE);
            lane02_drive_en <= (state_d != `IN_QUIET);
            lane13_drive_en <= (QUAD_CAPABLE != 0) && (state_d != `IN_QUIET)
                && (state_d != `IN_SEARCH);
            tx_select <= tx_sel_d;
            tx_control_taken <= (tx_sel_d == `TX_CONTROL);
            tx_packet_taken <= (tx_sel_d == `TX_PACKET);
            all_lanes_locked <= mon_locked;
            column_mismatch <= mon_mismatch;
            full_marker_column <= mon_full;
        end
    end

endmodule // link_init_ctrl

`default_nettype wire

// [lane_align_defines.vh]
// Constants for the lane alignment monitor and link initialization controllers
`ifndef LANE_ALIGN_DEFINES_VH
`define LANE_ALIGN_DEFINES_VH

`define CLK_PERIOD_PS 4000
`define QUIET_TIME_US 120
`define PROBE_TIME_MS 12
`define QUIET_CYCLES ((`QUIET_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define PROBE_CYCLES ((`PROBE_TIME_MS * 1000000) / (`CLK_PERIOD_PS / 1000))
`define TIMER_W 24
`define ALIGN_TARGET 3'h4
`define ACNT_W 3

// Alignment monitor states
`define AL_UNALIGNED 3'h0
`define AL_UNALIGNED_1 3'h1
`define AL_UNALIGNED_2 3'h2
`define AL_LOCKED 3'h3
`define AL_RECOVER_1 3'h4
`define AL_RECOVER_2 3'h5
`define AL_RECOVER_3 3'h6

// Init controller states
`define IN_QUIET 3'h0
`define IN_SEARCH 3'h1
`define IN_PROBE 3'h2
`define IN_SINGLE 3'h3
`define IN_PRIMARY 3'h4
`define IN_ALTERNATE 3'h5
`define IN_QUAD 3'h6

// Transmit symbol selects
`define TX_IDLE 2'h0
`define TX_CONTROL 2'h1
`define TX_PACKET 2'h2

`endif

// [lane_align_monitor.v]
// Four-lane column alignment monitor with marker hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "lane_align_defines.vh"

module lane_align_monitor (
    input wire core_clk,
    input wire resetn,
    input wire column_valid,
    input wire [3:0] lane_marker,
    input wire every_lane_locked,
    output reg all_lanes_locked,
    output reg column_mismatch,
    output reg full_marker_column
);

    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [`ACNT_W-1:0] full_cnt_q;
    reg [`ACNT_W-1:0] full_cnt_d;
    reg [`ACNT_W-1:0] mis_cnt_q;
    reg [`ACNT_W-1:0] mis_cnt_d;
    wire full_col;
    wire mis_col;

    assign full_col = column_valid & (&lane_marker);
    assign mis_col = column_valid & (|lane_marker) & ~(&lane_marker);

    always @* begin
        state_d = state_q;
        full_cnt_d = full_cnt_q;
        mis_cnt_d = mis_cnt_q;
        case (state_q)
            `AL_UNALIGNED: begin
                full_cnt_d = {`ACNT_W{1'b0}};
                if (every_lane_locked && full_col) begin
                    state_d = `AL_UNALIGNED_1;
                    full_cnt_d = {{(`ACNT_W-1){1'b0}}, 1'b1};
                end
            end
            `AL_UNALIGNED_1, `AL_UNALIGNED_2: begin
                if (!every_lane_locked || mis_col) begin
                    state_d = `AL_UNALIGNED;
                end else if (full_col) begin
                    full_cnt_d = full_cnt_q + 3'h1;
                    if (full_cnt_d == `ALIGN_TARGET) begin
                        state_d = `AL_LOCKED;
                    end else begin
                        state_d = `AL_UNALIGNED_2;
                    end
                end
            end
            `AL_LOCKED: begin
                mis_cnt_d = {`ACNT_W{1'b0}};
                full_cnt_d = {`ACNT_W{1'b0}};
                if (!every_lane_locked) begin
                    state_d = `AL_UNALIGNED;
                end else if (mis_col) begin
                    state_d = `AL_RECOVER_1;
                    mis_cnt_d = {{(`ACNT_W-1){1'b0}}, 1'b1};
                end
            end
            `AL_RECOVER_1, `AL_RECOVER_2, `AL_RECOVER_3: begin
                if (!every_lane_locked || mis_col) begin
                    state_d = `AL_UNALIGNED;
                end else if (full_col) begin
                    full_cnt_d = full_cnt_q + 3'h1;
                    if (full_cnt_d == `ALIGN_TARGET) begin
                        state_d = `AL_LOCKED;
                    end else if (state_q == `AL_RECOVER_1) begin
                        state_d = `AL_RECOVER_2;
                    end else begin
                        state_d = `AL_RECOVER_3;
                    end
                end
            end
            default: state_d = `AL_UNALIGNED;
        endcase
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= `AL_UNALIGNED;
            full_cnt_q <= {`ACNT_W{1'b0}};
            mis_cnt_q <= {`ACNT_W{1'b0}};
            all_lanes_locked <= 1'b0;
            column_mismatch <= 1'b0;
            full_marker_column <= 1'b0;
        end else begin
            state_q <= state_d;
            full_cnt_q <= full_cnt_d;
            mis_cnt_q <= mis_cnt_d;
            all_lanes_locked <= (state_d != `AL_UNALIGNED) && (state_d != `AL_UNALIGNED_1)
                && (state_d != `AL_UNALIGNED_2);
            column_mismatch <= mis_col;
            full_marker_column <= full_col;
        end
    end

endmodule // lane_align_monitor

`default_nettype wire

// [link_init_ctrl_assertions.sv]
// Port-level assertion checker for the link initialization controller
`timescale 1ns/1ps
`default_nettype none
`include "lane_align_defines.vh"
module link_init_ctrl_checker #(
    parameter QUAD_CAPABLE = 1
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic reinit_request,
    input wire logic column_valid,
    input wire logic [3:0] lane_marker,
    input wire logic link_up,
    input wire logic quad_mode,
    input wire logic alt_lane_select,
    input wire logic lane02_drive_en,
    input wire logic lane13_drive_en,
    input wire logic [1:0] tx_select,
    input wire logic tx_control_taken,
    input wire logic tx_packet_taken,
    input wire logic column_mismatch,
    input wire logic full_marker_column
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (!resetn);
////////////////////////////////////////////////////////////////////////////////
sequence s_full_col;
    QUAD_CAPABLE != 0 && column_valid && lane_marker == 4'hF;
endsequence
sequence s_part_col;
    QUAD_CAPABLE != 0 && column_valid && lane_marker != 4'h0 && lane_marker != 4'hF;
endsequence
a_up_needs_driver: assert property (link_up |-> lane02_drive_en)
    else $error("link up with driver off");
a_idle_when_down: assert property (!link_up |-> tx_select == `TX_IDLE)
    else $error("traffic while link down");
a_control_first: assert property (tx_control_taken |-> tx_select == `TX_CONTROL && !tx_packet_taken)
    else $error("control offer not selected");
a_quad_all_lanes: assert property (quad_mode |-> link_up && lane13_drive_en && !alt_lane_select)
    else $error("quad state without all drivers");
a_reinit_to_quiet: assert property (reinit_request |=> !link_up && !lane02_drive_en && !lane13_drive_en)
    else $error("reinit did not silence the port");
a_search_before_up: assert property ($rose(lane02_drive_en) |-> !link_up)
    else $error("driver enabled straight into link up");
a_single_no_quad: assert property (QUAD_CAPABLE == 0 |-> !lane13_drive_en && !quad_mode)
    else $error("single-lane port drove lanes 1 and 3");
a_full_flagged: assert property (s_full_col |-> ##2 full_marker_column && !column_mismatch)
    else $error("full marker column not flagged");
a_partial_flagged: assert property (s_part_col |-> ##2 column_mismatch && !full_marker_column)
    else $error("partial marker column not flagged");
endmodule // link_init_ctrl_checker

bind link_init_ctrl link_init_ctrl_checker #(.QUAD_CAPABLE(QUAD_CAPABLE)) chk_u (
    .core_clk(core_clk), .resetn(resetn), .reinit_request(reinit_request),
    .column_valid(column_valid), .lane_marker(lane_marker), .link_up(link_up),
    .quad_mode(quad_mode), .alt_lane_select(alt_lane_select), .tx_select(tx_select),
    .lane02_drive_en(lane02_drive_en), .lane13_drive_en(lane13_drive_en),
    .tx_control_taken(tx_control_taken), .tx_packet_taken(tx_packet_taken),
    .column_mismatch(column_mismatch), .full_marker_column(full_marker_column));
`default_nettype wire

// [peer_port_model.sv]
// Far-end port model: lane locks follow our drivers, marker columns when aligned
`timescale 1ns/1ps
`default_nettype none
module peer_port_model #(
    parameter LOCK_DLY = 8
) (
    input wire logic core_clk,
    input wire logic lane02_drive_en,
    input wire logic lane13_drive_en,
    input wire logic quad_ok,
    input wire logic [3:0] lane_mask,
    input wire logic err_req,
    output var logic [3:0] lane_locked,
    output var logic column_valid,
    output var logic [3:0] lane_marker
);
localparam logic [7:0] LOCK_V = LOCK_DLY;
logic [7:0] dly02_q = 8'h00;
logic [7:0] dly13_q = 8'h00;
logic [1:0] phase_q = 2'h0;
logic err_pend_q = 1'b0;
logic col_now;
assign col_now = phase_q == 2'h3 && lane_locked == 4'hF;
initial lane_locked = 4'h0;
initial column_valid = 1'b0;
initial lane_marker = 4'h0;
always @(posedge core_clk) begin
    // Silence on our side drops the peer's lock
    dly02_q <= !lane02_drive_en ? 8'h00 : (dly02_q == LOCK_V ? dly02_q : dly02_q + 8'h01);
    dly13_q <= !(lane13_drive_en && quad_ok) ? 8'h00 :
        (dly13_q == LOCK_V ? dly13_q : dly13_q + 8'h01);
    lane_locked <= {dly13_q == LOCK_V, dly02_q == LOCK_V, dly13_q == LOCK_V,
        dly02_q == LOCK_V} & lane_mask;
    phase_q <= phase_q + 2'h1;
    err_pend_q <= err_req | (err_pend_q & ~col_now);
    column_valid <= col_now;
    // Outside columns the marker lines carry a changing pattern
    lane_marker <= col_now ? (err_pend_q ? 4'h1 : 4'hF) : {phase_q, ~phase_q};
end
endmodule // peer_port_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the dual-width and single-lane init controllers
`timescale 1ns/1ps
`default_nettype none
`include "lane_align_defines.vh"
module tb_top;
logic core_clk = 1'b0;
logic resetn = 1'b0;
logic reinit_request = 1'b0;
logic single_lane_override = 1'b0;
logic alt_lane_override = 1'b0;
logic tx_control_valid = 1'b0;
logic tx_packet_valid = 1'b0;
logic quad_ok = 1'b1;
logic err_req = 1'b0;
logic [3:0] lane_mask = 4'hF;
logic s_quad_ok = 1'b0;
logic [3:0] s_mask = 4'h1;
wire [3:0] lane_locked, s_locked, lane_marker, s_marker;
wire column_valid, s_col, link_up, quad_mode, alt_lane_select, all_lanes_locked;
wire lane02_drive_en, lane13_drive_en, tx_control_taken, s_up, s_drv02, s_drv13;
wire tx_packet_taken;
wire [1:0] tx_select;
int fails = 0;
int total_checks = 0;
always #2 core_clk = ~core_clk;
////////////////////////////////////////////////////////////////////////////////
link_init_ctrl #(.QUIET_COUNT(24'h14), .PROBE_COUNT(24'h32)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .reinit_request(reinit_request),
    .single_lane_override(single_lane_override), .alt_lane_override(alt_lane_override),
    .lane_locked(lane_locked), .column_valid(column_valid), .lane_marker(lane_marker),
    .tx_control_valid(tx_control_valid), .tx_packet_valid(tx_packet_valid),
    .link_up(link_up), .quad_mode(quad_mode), .alt_lane_select(alt_lane_select),
    .lane02_drive_en(lane02_drive_en), .lane13_drive_en(lane13_drive_en),
    .tx_select(tx_select), .tx_control_taken(tx_control_taken),
    .tx_packet_taken(tx_packet_taken),
    .all_lanes_locked(all_lanes_locked), .column_mismatch(), .full_marker_column());
link_init_ctrl #(.QUAD_CAPABLE(0), .QUIET_COUNT(24'h14), .PROBE_COUNT(24'h32)) dut_s (
    .core_clk(core_clk), .resetn(resetn), .reinit_request(reinit_request),
    .single_lane_override(single_lane_override), .alt_lane_override(alt_lane_override),
    .lane_locked(s_locked), .column_valid(s_col), .lane_marker(s_marker),
    .tx_control_valid(tx_control_valid), .tx_packet_valid(tx_packet_valid),
    .link_up(s_up), .quad_mode(), .alt_lane_select(), .lane02_drive_en(s_drv02),
    .lane13_drive_en(s_drv13), .tx_select(), .tx_control_taken(), .tx_packet_taken(),
    .all_lanes_locked(), .column_mismatch(), .full_marker_column());
peer_port_model p_u (.core_clk(core_clk), .lane02_drive_en(lane02_drive_en),
    .lane13_drive_en(lane13_drive_en), .quad_ok(quad_ok), .lane_mask(lane_mask),
    .err_req(err_req), .lane_locked(lane_locked), .column_valid(column_valid),
    .lane_marker(lane_marker));
peer_port_model p_s (.core_clk(core_clk), .lane02_drive_en(s_drv02),
    .lane13_drive_en(s_drv13), .quad_ok(s_quad_ok), .lane_mask(s_mask), .err_req(err_req),
    .lane_locked(s_locked), .column_valid(s_col), .lane_marker(s_marker));
////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
        fails++;
        $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
endtask
task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask
task automatic wait_up(input logic sel, input logic val);
    int n;
    n = 0;
    while ((sel ? s_up : link_up) !== val && n < 600) begin
        @(negedge core_clk);
        n++;
    end
    if (n >= 600) begin
        fails++;
        final_report();
    end
endtask
task automatic pulse_err();
    err_req = 1'b1;
    @(negedge core_clk);
    err_req = 1'b0;
endtask
task automatic sc_startup();
    check({lane02_drive_en, lane13_drive_en, link_up}, 4'h0);
    check({s_drv02, s_up}, 4'h0);
    wait_up(1'b1, 1'b1);
    check({s_drv02, s_drv13}, 4'h2);
    wait_up(1'b0, 1'b1);
    check({quad_mode, lane13_drive_en, alt_lane_select}, 4'h6);
    check(all_lanes_locked, 4'h1);
endtask
task automatic sc_tx();
    tx_control_valid = 1'b1;
    tx_packet_valid = 1'b1;
    @(negedge core_clk);
    check(tx_select, `TX_CONTROL);
    check(tx_control_taken, 4'h1);
    tx_control_valid = 1'b0;
    @(negedge core_clk);
    check(tx_select, `TX_PACKET);
    check({tx_control_taken, tx_packet_taken}, 4'h1);
    tx_packet_valid = 1'b0;
    @(negedge core_clk);
    check(tx_select, `TX_IDLE);
endtask
task automatic sc_bit_error();
    logic drop;
    drop = 1'b0;
    pulse_err();
    repeat (40) begin
        @(negedge core_clk);
        drop = drop | (link_up !== 1'b1);
    end
    check(drop, 4'h0);
    check(all_lanes_locked, 4'h1);
    pulse_err();
    repeat (5) @(negedge core_clk);
    pulse_err();
    wait_up(1'b0, 1'b0);
    check({quad_mode, all_lanes_locked}, 4'h0);
endtask
task automatic sc_reinit();
    wait_up(1'b0, 1'b1);
    tx_control_valid = 1'b1;
    reinit_request = 1'b1;
    @(negedge core_clk);
    reinit_request = 1'b0;
    check({link_up, lane02_drive_en, lane13_drive_en}, 4'h0);
    check(s_up, 4'h0);
    @(negedge core_clk);
    check(tx_select, `TX_IDLE);
    tx_control_valid = 1'b0;
endtask
task automatic sc_modes();
    logic [7:0] tab [4] = '{8'hFA, 8'h50, 8'h55, 8'h41};
    for (int i = 0; i < 4; i++) begin
        @(negedge core_clk);
        {lane_mask, single_lane_override, alt_lane_override, quad_ok} = tab[i][7:1];
        reinit_request = 1'b1;
        @(negedge core_clk);
        reinit_request = 1'b0;
        wait_up(1'b0, 1'b1);
        check({quad_mode, alt_lane_select}, {3'h0, tab[i][0]});
        lane_mask = 4'h0;
        wait_up(1'b0, 1'b0);
        check(link_up, 4'h0);
    end
    wait_up(1'b1, 1'b1);
    s_mask = 4'h0;
    wait_up(1'b1, 1'b0);
    check({s_up, s_drv13}, 4'h0);
endtask
initial begin
    repeat (16) @(negedge core_clk);
    resetn = 1'b1;
    sc_startup();
    sc_tx();
    sc_bit_error();
    sc_reinit();
    sc_modes();
    final_report();
end
endmodule // tb_top
`default_nettype wire
